//--- test/gpio_spi_master_config_checker.sv
// Port checker for the serial master.
// Assumes one core clock and the raw active-low reset.
`timescale 1ns/100ps
`default_nettype none
module gpio_spi_master_config_checker #(
  parameter int HALF_CYC = 4,
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset, register port
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [7:0] o_rdata,
  // Pins
  input wire logic [3:0] i_gpio_out,
  input wire logic [3:0] i_gpio_oe,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe
);
  logic [6:0] cfg_r;
  logic [7:0] tx_r, act_r;
  logic [2:0] up_r;
  logic settled;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Pins only trusted once the internal reset copy has let go
  assign settled = (up_r == 3'h4);
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= 7'h10;
      tx_r <= 8'h00;
      act_r <= 8'h00;
      up_r <= 3'h0;
    end else begin
      up_r <= settled ? up_r : up_r + 3'h1;
      // Pins change on the same edge as the field they follow
      act_r <= (cfg_r[3] && o_pin_out[1] != cfg_r[6]) ? act_r + 8'h01 : 8'h00;
      if (i_we && i_addr == 10'h154)
        cfg_r <= i_wdata[6:0];
      if (i_we && i_addr == 10'h155)
        tx_r <= i_wdata;
    end
  end
  a_rdata_idle_zero: assert property (!i_re |=> o_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_cfg_read_back: assert property (i_re && i_addr == 10'h154 |=> o_rdata == {1'b0, $past(cfg_r)})
    else $error("config read back wrong");
  a_tx_read_back: assert property (i_re && i_addr == 10'h155 |=> o_rdata == $past(tx_r))
    else $error("transmit byte read back wrong");
  a_launch_reads_zero: assert property (i_re && i_addr == 10'h156 |=> o_rdata == 8'h00)
    else $error("launch register not zero");
  a_unmapped_zero: assert property (i_re && i_addr > 10'h158 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_select_level: assert property (settled && cfg_r[3] |-> o_pin_out[0] == cfg_r[4])
    else $error("select pin off its field");
  a_pins_taken: assert property (settled && cfg_r[3] |-> o_pin_oe == 4'h7 && o_pin_out[3] == 1'b0)
    else $error("pin enables wrong while master on");
  a_gpio_pass: assert property (settled && !cfg_r[3] |->
    o_pin_out == $past(i_gpio_out) && o_pin_oe == $past(i_gpio_oe))
    else $error("gpio values not passed");
  a_sclk_pulse: assert property (settled && cfg_r[3] && o_pin_out[1] == cfg_r[6] && act_r != 8'h00
    |-> act_r == 8'(HALF_CYC))
    else $error("clock pulse wrong length or level");
endmodule
`default_nettype wire

//--- test/gpio_spi_master_config_tb.sv
// Bench: register port, random gpio traffic, transfers in every mode and length.
// Assumes the slave model on pins 3 to 6 and the checker bound below.
`timescale 1ns/100ps
`default_nettype none
module gpio_spi_master_config_tb;
  logic i_core_clk, i_rst_n, i_we, i_re, miso, pol, pha;
  logic re_d = 1'b0;
  logic gin_on = 1'b0;
  logic [3:0] gpio_in, pd1, pd2;
  logic [9:0] i_addr;
  logic [7:0] i_wdata, o_rdata, reply, got, d, r, msk;
  logic [3:0] i_gpio_out = 4'h0;
  logic [3:0] i_gpio_oe = 4'h0;
  logic [3:0] rnd_pin = 4'h0;
  logic [3:0] o_pin_out, o_pin_oe, cnt;
  logic [7:0] exp_q[$];
  int fails, cmp_count, i, k, n;
  integer seed = 32'h55F0F297;
  gpio_spi_master_config #(.HALF_CYC(4), .FIFO_DEPTH(16)) dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_gpio_out(i_gpio_out),
    .i_gpio_oe(i_gpio_oe), .o_gpio_in(gpio_in), .i_pin_in({miso, rnd_pin[2:0]}),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
  spi_slave_model u_slave (.i_sel_n(o_pin_out[0]), .i_sclk(o_pin_out[1]), .i_mosi(o_pin_out[2]),
    .o_miso(miso), .i_clock_idle_polarity(pol), .i_sample_edge_select(pha), .i_reply(reply), .o_got(got), .o_cnt(cnt));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= v;
    i_we <= 1'b1;
    @(posedge i_core_clk);
    i_we <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_re <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_core_clk);
    i_re <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge i_core_clk) begin
    if (re_d && exp_q.size() > 0)
      check("rdata", o_rdata, exp_q.pop_front());
    re_d <= i_re;
    // Pads reach the gpio input after the two sync flops
    if (gin_on)
      check("gpio_in", {4'h0, gpio_in}, {4'h0, pd2});
    pd1 <= {miso, rnd_pin[2:0]};
    pd2 <= pd1;
    i_gpio_out <= 4'($random(seed));
    i_gpio_oe <= 4'($random(seed));
    rnd_pin <= 4'($random(seed));
  end
  // About twenty times the expected run
  initial begin
    #400000;
    fails++;
    close_out();
  end
  initial begin
    {i_rst_n, i_we, i_re, pol, pha} = 5'h00;
    {i_addr, i_wdata, reply} = 26'h0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd(10'h154, 8'h10);
    gin_on <= 1'b1;
    rd(10'h155, 8'h00);
    rd(10'h159, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(10'h154, d);
      rd(10'h154, {1'b0, d[6:0]});
      wr(10'h155, ~d);
      rd(10'h155, ~d);
    end
    // ---------------------------------
    // Every mode with every length code
    // ---------------------------------
    for (i = 0; i < 32; i++) begin
      n = (i[2:0] == 3'h0) ? 8 : i[2:0];
      d = 8'($random(seed));
      r = 8'($random(seed));
      reply <= r;
      pol <= i[4];
      pha <= i[3];
      wr(10'h154, {1'b0, i[4], i[3], 1'b1, 1'b1, i[2:0]});
      wr(10'h155, d);
      wr(10'h154, {1'b0, i[4], i[3], 1'b0, 1'b1, i[2:0]});
      wr(10'h156, 8'h01);
      rd(10'h156, 8'h00);
      // Busy set, queue already drained by the engine
      rd(10'h157, 8'h01);
      for (k = 0; k < 300 && cnt != 4'(n); k++)
        @(posedge i_core_clk);
      repeat (12) @(posedge i_core_clk);
      msk = 8'hFF >> (8 - n);
      check("mosi", got, d & msk);
      check("count", {4'h0, cnt}, 8'(n));
      wr(10'h154, {1'b0, i[4], i[3], 1'b1, 1'b1, i[2:0]});
      rd(10'h158, r & msk);
      rd(10'h157, 8'h00);
    end
    close_out();
  end
endmodule
bind gpio_spi_master_config gpio_spi_master_config_checker #(.HALF_CYC(HALF_CYC), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
  .i_re(i_re), .o_rdata(o_rdata), .i_gpio_out(i_gpio_out), .i_gpio_oe(i_gpio_oe),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
`default_nettype wire

//--- test/spi_slave_model.sv
// Serial slave model on the borrowed pins.
// Assumes the bench sets mode and reply byte before select falls.
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model (
  // Pins
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  // Mode and data
  input wire logic i_clock_idle_polarity,
  input wire logic i_sample_edge_select,
  input wire logic [7:0] i_reply,
  output logic [7:0] o_got,
  output logic [3:0] o_cnt
);
  logic [7:0] rep = 8'h00;
  logic sel_q = 1'b1;
  // One process owns every output of the model
  initial begin
    o_miso = 1'b0;
    o_got = 8'h00;
    o_cnt = 4'h0;
    forever begin
      @(i_sel_n or i_sclk);
      if (i_sel_n !== sel_q) begin
        sel_q = i_sel_n;
        if (i_sel_n === 1'b0) begin
          o_cnt = 4'h0;
          o_got = 8'h00;
          rep = i_reply;
          if (!i_sample_edge_select)
            o_miso = rep[0];
        end else begin
          // Released line flips to the inverse of its last bit
          o_miso = ~o_miso;
        end
      end else if (i_sel_n === 1'b0) begin
        if ((i_sclk != i_clock_idle_polarity) ^ i_sample_edge_select) begin
          o_got[o_cnt[2:0]] = i_mosi;
          o_cnt = o_cnt + 4'h1;
        end else begin
          o_miso = rep[o_cnt[2:0]];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/byte_fifo.sv
// Small flop-based FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous-released active-low reset.
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign o_in_ready = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign o_out_valid = (wr_r != rd_r);
  assign o_out_data = mem_r[rd_r[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

  // Storage needs no reset; only pointers qualify it
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= i_in_data;
    end
  end

endmodule

`default_nettype wire

//--- verilog/gpio_spi_master_config.sv
// Serial master that borrows GPIO pins 3 to 6, with its register file.
// Assumes a same-clock register port; pins come from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "spi_master_consts.svh"

module gpio_spi_master_config #(
  parameter int HALF_CYC = `SCLK_HALF_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [7:0] o_rdata,
  // Normal GPIO function for pins 3..6
  input wire logic [3:0] i_gpio_out,
  input wire logic [3:0] i_gpio_oe,
  output logic [3:0] o_gpio_in,
  // Pins 3..6: select, clock, data out, data in
  input wire logic [3:0] i_pin_in,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe
);

  // ----------------------------------------
  // Pin map inside the borrowed group
  // ----------------------------------------
  localparam int PIN_SS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 3;
  localparam logic [3:0] SPI_OE = 4'h7;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic rst_n;
  logic [3:0] pin_sync;

  sync2 #(
    .WIDTH(1)
  ) u_rst_sync (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(rst_n)
  );

  sync2 #(
    .WIDTH(4)
  ) u_pin_sync (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_d(i_pin_in),
    .o_q(pin_sync)
  );

  assign o_gpio_in = pin_sync;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // length decode
  function automatic logic [3:0] bits_of(input logic [2:0] code);
    bits_of = (code == 3'h0) ? 4'h8 : {1'b0, code};
  endfunction

  function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
    hit = (a == b);
  endfunction

  // ----------------------------------------
  // Launch queue
  // ----------------------------------------
  spi_master_pkg::core_state_t s_r;
  spi_master_pkg::core_state_t s_nxt;
  logic q_in_valid;
  logic q_in_ready;
  logic q_out_valid;
  logic q_out_ready;
  logic [12:0] q_in_data;
  logic [12:0] q_out_data;
  logic en;

  assign en = s_r.cfg[`CFG_EN];

  assign q_in_valid = i_we && hit(i_addr, `ADDR_EXE) && i_wdata[`EXE_GO];
  // Snapshot of shape and data so later writes cannot corrupt a queued transfer
  assign q_in_data = {s_r.cfg[`CFG_IDLE_POL], s_r.cfg[`CFG_SAMPLE_EDGE], s_r.cfg[2:0], s_r.tx};
  assign q_out_ready = en && (s_r.state == spi_master_pkg::ST_IDLE);

  byte_fifo #(
    .WIDTH(13),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_in_valid(q_in_valid),
    .o_in_ready(q_in_ready),
    .i_in_data(q_in_data),
    .o_out_valid(q_out_valid),
    .i_out_ready(q_out_ready),
    .o_out_data(q_out_data)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;

    // Register writes
    if (i_we) begin
      if (hit(i_addr, `ADDR_CFG)) begin
        s_nxt.cfg = i_wdata[6:0];
      end
      if (hit(i_addr, `ADDR_TX)) begin
        s_nxt.tx = i_wdata;
      end
      if (hit(i_addr, `ADDR_STAT) && i_wdata[`STAT_DROP]) begin
        s_nxt.drop = 1'b0;
      end
    end
    // Lost launch; set wins over clear
    if (q_in_valid && !q_in_ready) begin
      s_nxt.drop = 1'b1;
    end

    // Register reads, data valid one cycle later only
    if (i_re) begin
      if (hit(i_addr, `ADDR_CFG)) begin
        s_nxt.rdata = {1'b0, s_r.cfg};
      end else if (hit(i_addr, `ADDR_TX)) begin
        s_nxt.rdata = s_r.tx;
      end else if (hit(i_addr, `ADDR_EXE)) begin
        s_nxt.rdata = 8'h00;
      end else if (hit(i_addr, `ADDR_STAT)) begin
        s_nxt.rdata = {4'h0, q_out_valid, s_r.drop, !q_in_ready,
                       (s_r.state != spi_master_pkg::ST_IDLE)};
      end else if (hit(i_addr, `ADDR_RX)) begin
        s_nxt.rdata = s_r.rx_last;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end

    // Transfer engine
    unique case (s_r.state)
      spi_master_pkg::ST_IDLE: begin
        // idle level tracks live polarity
        // Taken from the incoming write so the clock pin moves with select
        s_nxt.sclk = s_nxt.cfg[`CFG_IDLE_POL];
        if (q_out_valid && en) begin
          s_nxt.idle_pol_c = q_out_data[12];
          s_nxt.sample_edge_c = q_out_data[11];
          s_nxt.nbits = bits_of(q_out_data[10:8]);
          s_nxt.sh = q_out_data[7:0];
          s_nxt.mosi = q_out_data[0];
          s_nxt.sclk = q_out_data[12];
          s_nxt.bitn = 4'h0;
          s_nxt.rx = 8'h00;
          s_nxt.lead = 1'b1;
          s_nxt.div = HALF_LAST;
          s_nxt.state = spi_master_pkg::ST_SHIFT;
        end
      end
      spi_master_pkg::ST_SHIFT: begin
        if (s_r.div != 8'h00) begin
          s_nxt.div = s_r.div - 8'h01;
        end else begin
          s_nxt.div = HALF_LAST;
          if (s_r.lead) begin
            // active level is the opposite of idle
            s_nxt.sclk = !s_r.idle_pol_c;
            s_nxt.lead = 1'b0;
            if (!s_r.sample_edge_c) begin
              // phase 0 samples on first edge
              s_nxt.rx = {pin_sync[PIN_MISO], s_r.rx[7:1]};
            end else begin
              // phase 1 drives on first edge
              s_nxt.mosi = s_r.sh[0];
            end
          end else begin
            s_nxt.sclk = s_r.idle_pol_c;
            s_nxt.lead = 1'b1;
            s_nxt.sh = {1'b0, s_r.sh[7:1]};
            if (s_r.sample_edge_c) begin
              // phase 1 samples on second edge
              s_nxt.rx = {pin_sync[PIN_MISO], s_r.rx[7:1]};
            end else begin
              // phase 0 drives next bit on second edge
              s_nxt.mosi = s_r.sh[1];
            end
            s_nxt.bitn = s_r.bitn + 4'h1;
            if (s_r.bitn + 4'h1 == s_r.nbits) begin
              s_nxt.state = spi_master_pkg::ST_HOLD;
            end
          end
        end
      end
      spi_master_pkg::ST_HOLD: begin
        // Half period of idle clock before the next transfer may start
        if (s_r.div != 8'h00) begin
          s_nxt.div = s_r.div - 8'h01;
        end else begin
          s_nxt.state = spi_master_pkg::ST_DONE;
        end
      end
      spi_master_pkg::ST_DONE: begin
        // Received bits arrive at the top; align them to bit 0
        s_nxt.rx_last = s_r.rx >> (4'h8 - s_r.nbits);
        s_nxt.state = spi_master_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.state = spi_master_pkg::ST_IDLE;
      end
    endcase

    // Disabling mid-transfer abandons it; partial data is not kept
    if (!en && s_r.state != spi_master_pkg::ST_IDLE) begin
      s_nxt.state = spi_master_pkg::ST_IDLE;
      s_nxt.sclk = s_nxt.cfg[`CFG_IDLE_POL];
    end

    // ----------------------------------------
    // Pin ownership
    // ----------------------------------------
    // master overrides GPIO settings
    if (s_nxt.cfg[`CFG_EN]) begin
      s_nxt.pin_oe = SPI_OE;
      // select is the field, never automatic
      s_nxt.pin_out[PIN_SS] = s_nxt.cfg[`CFG_SS];
      s_nxt.pin_out[PIN_SCLK] = s_nxt.sclk;
      s_nxt.pin_out[PIN_MOSI] = s_nxt.mosi;
      s_nxt.pin_out[PIN_MISO] = 1'b0;
    end else begin
      s_nxt.pin_oe = i_gpio_oe;
      s_nxt.pin_out = i_gpio_out;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.cfg <= `CFG_RST;
      s_r.tx <= `TX_RST;
      s_r.rx_last <= `RX_RST;
      s_r.state <= spi_master_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_pin_out = s_r.pin_out;
  assign o_pin_oe = s_r.pin_oe;

endmodule

`default_nettype wire

//--- verilog/spi_master_consts.svh
// Constants for the pin-borrowing serial master: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files.
`ifndef SPI_MASTER_CONSTS_SVH
`define SPI_MASTER_CONSTS_SVH

// ----------------------------------------
// Register offsets (10-bit byte address)
// ----------------------------------------
`define ADDR_CFG 10'h154
`define ADDR_TX 10'h155
`define ADDR_EXE 10'h156
`define ADDR_STAT 10'h157
`define ADDR_RX 10'h158

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_IDLE_POL 6
`define CFG_SAMPLE_EDGE 5
`define CFG_SS 4
`define CFG_EN 3
`define EXE_GO 0
`define STAT_BUSY 0
`define STAT_FULL 1
`define STAT_DROP 2
`define STAT_PEND 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_RST 7'h10
`define TX_RST 8'h00
`define RX_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_CLK_MHZ 100
`define SCLK_PERIOD_NS 80
`define SCLK_HALF_CYC ((`SCLK_PERIOD_NS * `CORE_CLK_MHZ) / 2000)

`endif

//--- verilog/spi_master_pkg.sv
// Types for the pin-borrowing serial master.
// Assumes nothing beyond the constants header.
`default_nettype none
package spi_master_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SHIFT = 4'h2,
    ST_HOLD = 4'h4,
    ST_DONE = 4'h8
  } eng_state_t;

  typedef struct packed {
    logic [6:0] cfg;
    logic [7:0] tx;
    logic [7:0] rdata;
    eng_state_t state;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [3:0] nbits;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [7:0] rx_last;
    logic idle_pol_c;
    logic sample_edge_c;
    logic lead;
    logic sclk;
    logic mosi;
    logic drop;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
  } core_state_t;

endpackage

`default_nettype wire

//--- verilog/sync2.sv
// Two-flop synchroniser for levels from outside the core clock.
// Assumes asynchronous active-low reset; first stage feeds second only.
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end

endmodule

`default_nettype wire
